// ---- logic/dnpa_consts.svh ----
`ifndef DNPA_CONSTS_SVH
`define DNPA_CONSTS_SVH

// ****************************************
// Register word indices (byte address = 4 x index)
// ****************************************
`define DNPA_IDX_ADDR_LOW   3'h0
`define DNPA_IDX_ADDR_HIGH  3'h1
`define DNPA_IDX_DATA       3'h2
`define DNPA_IDX_CONTROL    3'h3
`define DNPA_IDX_STATUS     3'h4

// ****************************************
// Control register bit positions
// ****************************************
`define DNPA_CTL_FETCH_GO   0
`define DNPA_CTL_FETCH_ARM  1
`define DNPA_CTL_PROG_GO    2
`define DNPA_CTL_PROG_ARM   3
`define DNPA_CTL_MODE       4
`define DNPA_CTL_WIPE_GO    5
`define DNPA_CTL_WIPE_ARM   6
`define DNPA_CTL_TIMING     7

// ****************************************
// Status register bit positions
// ****************************************
`define DNPA_STAT_DONE      0
`define DNPA_STAT_BUSY      1

// ****************************************
// Geometry and reset values
// ****************************************
`define DNPA_ADDR_W         9
`define DNPA_OFS_W          4
`define DNPA_PAGE_BYTES     16
`define DNPA_OFS_LAST       4'hf
`define DNPA_BYTE_RST       8'h00
`define DNPA_TIMER_W        17

// ****************************************
// Timing
// ****************************************
`define DNPA_CLK_NS         40
`define DNPA_T_ERASE_S_NS   3200000
`define DNPA_T_WRITE_S_NS   2200000
`define DNPA_T_ERASE_L_NS   3700000
`define DNPA_T_WRITE_L_NS   3000000
`define DNPA_CYC(t)         (((t) + `DNPA_CLK_NS - 1) / `DNPA_CLK_NS)

`endif

// ---- logic/dnpa_pkg.sv ----
package dnpa_pkg;

    // Cycle sequencer states, one-hot
    typedef enum logic [3:0] {
        DNPA_IDLE   = 4'b0001,
        DNPA_ERASE  = 4'b0010,
        DNPA_PROG   = 4'b0100,
        DNPA_FINISH = 4'b1000
    } dnpa_state_t;

endpackage

// ---- logic/dnpa_top.sv ----
// Contract
// - Mode high: page reads of up to 16 consecutive bytes from address pair.
// - fetch_go request ignored unless fetch_arm already high; no read starts.
// - Page byte read end clears fetch_go, loads data byte, increments address.
// - Page read: setting fetch_go again reads next byte, no reprogramming.
// - Upper 5 bits page, lower 4 offset; increment touches offset only.
// - Offset holds at 0FH instead of wrapping.
// - Page buffer cleared at reset and on wipe_arm falling, not rising.
// - Page erase: data write tags current address, increments offset.
// - Erase starts only when wipe_go is set the write right after wipe_arm.
// - Erase timed internally; wipe_go clears at end, then wipe_arm.
// - Erased byte locations read back as zero.
// - Erase completion seen through wipe_go clearing and the done request.
// - Byte write starts only when program_go follows program_arm directly.
// - program_go with program_arm low starts no write.
// - Write end clears program_go, then program_arm, and raises done request.
// - Byte write erases target byte before programming the new value.
// - Page buffer cleared on program_arm falling, not rising.
// - Page write: data write loads buffer at offset, offset increments.
// - After the data write at offset 0FH, further data writes are dropped.
// - timing_select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write.
// - done_irq_flag set whenever an erase or write cycle ends.
// - Array of 512 bytes, 9-bit address from low and high registers.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "dnpa_consts.svh"

module dnpa_top #(
    parameter int unsigned P_ERASE_S_CYC = `DNPA_CYC(`DNPA_T_ERASE_S_NS),
    parameter int unsigned P_WRITE_S_CYC = `DNPA_CYC(`DNPA_T_WRITE_S_NS),
    parameter int unsigned P_ERASE_L_CYC = `DNPA_CYC(`DNPA_T_ERASE_L_NS),
    parameter int unsigned P_WRITE_L_CYC = `DNPA_CYC(`DNPA_T_WRITE_L_NS)
) (
    input  wire logic        I_CLK,
    input  wire logic        I_ARST_N,
    input  wire logic [2:0]  I_ADDRESS,
    input  wire logic        I_READ,
    input  wire logic        I_WRITE,
    input  wire logic [31:0] I_WRITEDATA,
    input  wire logic [3:0]  I_BYTEENABLE,
    output logic      [31:0] O_READDATA,
    output logic             O_WAITREQUEST,
    output logic             O_DONE_IRQ
);

    localparam int AW    = `DNPA_ADDR_W;
    localparam int OW    = `DNPA_OFS_W;
    localparam int PW    = AW - OW;
    localparam int NPAGE = `DNPA_PAGE_BYTES;
    localparam int DEPTH = 1 << AW;
    localparam int TW    = `DNPA_TIMER_W;

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]                 addr_low;
    logic                       addr_high;
    logic [7:0]                 data_byte;
    logic                       timing_select;
    logic                       wipe_arm;
    logic                       wipe_go;
    logic                       page_mode;
    logic                       program_arm;
    logic                       program_go;
    logic                       fetch_arm;
    logic                       fetch_go;
    logic                       wipe_recent;
    logic                       prog_recent;
    logic                       wipe_arm_d;
    logic                       prog_arm_d;
    logic                       offset_full;
    logic [7:0]                 mem [0:DEPTH-1];
    logic [7:0]                 page_buf [0:NPAGE-1];
    logic [NPAGE-1:0]           tag;
    dnpa_pkg::dnpa_state_t      state;
    logic [TW-1:0]              timer;
    logic [PW-1:0]              cmd_page;
    logic [AW-1:0]              cmd_addr;
    logic [7:0]                 cmd_data;
    logic                       cmd_paged;
    logic [AW-1:0]              cur_addr;
    logic [OW-1:0]              cur_ofs;
    logic [7:0]                 wd;
    logic                       wr_take;
    logic                       wr_ctrl;
    logic                       wr_data;
    logic                       busy;
    logic                       start_erase;
    logic                       start_prog;
    logic                       start_fetch;
    logic                       end_cycle;
    logic                       buf_load;
    logic                       clear_buf;
    logic                       adv_ofs;
    logic [31:0]                rd_mux;

    // ****************************************
    // Request decode
    // ****************************************
    assign cur_addr = {addr_high, addr_low};
    assign cur_ofs  = addr_low[OW-1:0];
    assign wd       = I_WRITEDATA[7:0];
    assign wr_take  = I_WRITE && !O_WAITREQUEST && I_BYTEENABLE[0];
    assign wr_ctrl  = wr_take && (I_ADDRESS == `DNPA_IDX_CONTROL);
    assign wr_data  = wr_take && (I_ADDRESS == `DNPA_IDX_DATA);
    assign busy     = (state != dnpa_pkg::DNPA_IDLE);

    assign start_fetch = wr_ctrl && !busy && wd[`DNPA_CTL_FETCH_GO]
                         && fetch_arm && !fetch_go;
    assign start_erase = wr_ctrl && !busy && wd[`DNPA_CTL_WIPE_GO]
                         && wipe_arm && wipe_recent;
    assign start_prog  = wr_ctrl && !busy && wd[`DNPA_CTL_PROG_GO]
                         && program_arm && prog_recent;

    assign end_cycle = ((state == dnpa_pkg::DNPA_ERASE) || (state == dnpa_pkg::DNPA_PROG))
                       && (timer == '0);
    assign buf_load  = wr_data && !busy && page_mode && !offset_full;
    assign clear_buf = (wipe_arm_d && !wipe_arm) || (prog_arm_d && !program_arm);
    assign adv_ofs   = (buf_load || (fetch_go && page_mode)) && (cur_ofs != `DNPA_OFS_LAST);

    always_comb
    begin
        rd_mux = '0;
        case (I_ADDRESS)
            `DNPA_IDX_ADDR_LOW:  rd_mux[7:0] = addr_low;
            `DNPA_IDX_ADDR_HIGH: rd_mux[0]   = addr_high;
            `DNPA_IDX_DATA:      rd_mux[7:0] = data_byte;
            `DNPA_IDX_CONTROL:   rd_mux[7:0] = {timing_select, wipe_arm, wipe_go, page_mode,
                                                program_arm, program_go, fetch_arm, fetch_go};
            `DNPA_IDX_STATUS:
            begin
                rd_mux[`DNPA_STAT_DONE] = O_DONE_IRQ;
                rd_mux[`DNPA_STAT_BUSY] = busy;
            end
            default:             rd_mux = '0;
        endcase
    end

    // ****************************************
    // Avalon-MM slave handshake
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_WAITREQUEST <= 1'b1;
            O_READDATA    <= '0;
        end
        else if (O_WAITREQUEST && (I_READ || I_WRITE))
        begin
            O_WAITREQUEST <= 1'b0;
            O_READDATA    <= rd_mux;
        end
        else
        begin
            O_WAITREQUEST <= 1'b1;
        end
    end

    // ****************************************
    // Address pair and offset stepping
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            addr_low    <= `DNPA_BYTE_RST;
            addr_high   <= 1'b0;
            offset_full <= 1'b0;
        end
        else
        begin
            if (wr_take && !busy && (I_ADDRESS == `DNPA_IDX_ADDR_LOW))
                addr_low <= wd;
            else if (adv_ofs)
                addr_low[OW-1:0] <= cur_ofs + 4'h1;
            if (wr_take && !busy && (I_ADDRESS == `DNPA_IDX_ADDR_HIGH))
                addr_high <= wd[0];
            if (clear_buf || (wr_take && !busy && ((I_ADDRESS == `DNPA_IDX_ADDR_LOW)
                || (I_ADDRESS == `DNPA_IDX_ADDR_HIGH))))
                offset_full <= 1'b0;
            else if (buf_load && (cur_ofs == `DNPA_OFS_LAST))
                offset_full <= 1'b1;
        end
    end

    // ****************************************
    // Data register and read path
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            data_byte <= `DNPA_BYTE_RST;
        else if (fetch_go)
            data_byte <= mem[cur_addr];
        else if (wr_data && !busy)
            data_byte <= wd;
    end

    // ****************************************
    // Control bits
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            timing_select <= 1'b0;
            wipe_arm      <= 1'b0;
            wipe_go       <= 1'b0;
            page_mode     <= 1'b0;
            program_arm   <= 1'b0;
            program_go    <= 1'b0;
            fetch_arm     <= 1'b0;
            fetch_go      <= 1'b0;
            wipe_recent   <= 1'b0;
            prog_recent   <= 1'b0;
        end
        else
        begin
            if (wr_take)
            begin
                wipe_recent <= wr_ctrl && !busy && !wipe_arm && wd[`DNPA_CTL_WIPE_ARM];
                prog_recent <= wr_ctrl && !busy && !program_arm && wd[`DNPA_CTL_PROG_ARM];
            end
            if (fetch_go)
                fetch_go <= 1'b0;
            else if (start_fetch)
                fetch_go <= 1'b1;
            if (wr_ctrl && !busy)
            begin
                timing_select <= wd[`DNPA_CTL_TIMING];
                page_mode     <= wd[`DNPA_CTL_MODE];
                fetch_arm     <= wd[`DNPA_CTL_FETCH_ARM];
                wipe_arm      <= wd[`DNPA_CTL_WIPE_ARM];
                program_arm   <= wd[`DNPA_CTL_PROG_ARM];
                wipe_go       <= start_erase;
                program_go    <= start_prog;
            end
            if (end_cycle)
            begin
                wipe_go    <= 1'b0;
                program_go <= 1'b0;
            end
            if (state == dnpa_pkg::DNPA_FINISH)
            begin
                wipe_arm    <= 1'b0;
                program_arm <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            wipe_arm_d <= 1'b0;
            prog_arm_d <= 1'b0;
        end
        else
        begin
            wipe_arm_d <= wipe_arm;
            prog_arm_d <= program_arm;
        end
    end

    // ****************************************
    // Erase and write cycle sequencer
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state     <= dnpa_pkg::DNPA_IDLE;
            timer     <= '0;
            cmd_page  <= '0;
            cmd_addr  <= '0;
            cmd_data  <= `DNPA_BYTE_RST;
            cmd_paged <= 1'b0;
        end
        else
        begin
            case (state)
                dnpa_pkg::DNPA_IDLE:
                begin
                    cmd_page  <= cur_addr[AW-1:OW];
                    cmd_addr  <= cur_addr;
                    cmd_data  <= data_byte;
                    cmd_paged <= page_mode;
                    if (start_erase)
                    begin
                        state <= dnpa_pkg::DNPA_ERASE;
                        timer <= timing_select ? TW'(P_ERASE_L_CYC - 1)
                                               : TW'(P_ERASE_S_CYC - 1);
                    end
                    else if (start_prog)
                    begin
                        state <= dnpa_pkg::DNPA_PROG;
                        timer <= timing_select ? TW'(P_WRITE_L_CYC - 1)
                                               : TW'(P_WRITE_S_CYC - 1);
                    end
                end
                dnpa_pkg::DNPA_ERASE, dnpa_pkg::DNPA_PROG:
                begin
                    if (end_cycle)
                        state <= dnpa_pkg::DNPA_FINISH;
                    else
                        timer <= timer - TW'(1);
                end
                dnpa_pkg::DNPA_FINISH:
                    state <= dnpa_pkg::DNPA_IDLE;
                default:
                    state <= dnpa_pkg::DNPA_IDLE;
            endcase
        end
    end

    // ****************************************
    // Completion request
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_DONE_IRQ <= 1'b0;
        else if (end_cycle)
            O_DONE_IRQ <= 1'b1;
        else if (wr_take && (I_ADDRESS == `DNPA_IDX_STATUS) && wd[`DNPA_STAT_DONE])
            O_DONE_IRQ <= 1'b0;
    end

    // ****************************************
    // Page buffer, one slot per offset
    // ****************************************
    for (genvar i = 0; i < NPAGE; i++)
    begin : g_slot
        always_ff @(posedge I_CLK or negedge I_ARST_N)
        begin
            if (!I_ARST_N)
            begin
                tag[i]      <= 1'b0;
                page_buf[i] <= `DNPA_BYTE_RST;
            end
            else if (clear_buf)
            begin
                tag[i]      <= 1'b0;
                page_buf[i] <= `DNPA_BYTE_RST;
            end
            else if (buf_load && (cur_ofs == OW'(i)))
            begin
                tag[i]      <= 1'b1;
                page_buf[i] <= wd;
            end
        end
    end

    // ****************************************
    // Storage array commit
    // ****************************************
    always_ff @(posedge I_CLK)
    begin
        if (end_cycle)
        begin
            if (state == dnpa_pkg::DNPA_ERASE)
            begin
                for (int j = 0; j < NPAGE; j++)
                    if (tag[j])
                        mem[{cmd_page, OW'(j)}] <= `DNPA_BYTE_RST;
            end
            else if (cmd_paged)
            begin
                for (int j = 0; j < NPAGE; j++)
                    if (tag[j])
                        mem[{cmd_page, OW'(j)}] <= page_buf[j];
            end
            else
            begin
                mem[cmd_addr] <= cmd_data;
            end
        end
    end

endmodule

// ---- dv/dnpa_top_asserts.sv ----
`timescale 1ns/1ps
module dnpa_top_asserts #(
    parameter int unsigned P_ERASE_S_CYC = 80000,
    parameter int unsigned P_WRITE_S_CYC = 55000,
    parameter int unsigned P_ERASE_L_CYC = 92500,
    parameter int unsigned P_WRITE_L_CYC = 75000
) (
    input wire logic        I_CLK,
    input wire logic        I_ARST_N,
    input wire logic [2:0]  I_ADDRESS,
    input wire logic        I_READ,
    input wire logic        I_WRITE,
    input wire logic [31:0] I_WRITEDATA,
    input wire logic [3:0]  I_BYTEENABLE,
    input wire logic [31:0] O_READDATA,
    input wire logic        O_WAITREQUEST,
    input wire logic        O_DONE_IRQ
);
    // ****************************************
    // Cycles since the last control write carrying a program or wipe go bit
    // ****************************************
    logic        wr_ok;
    logic        rd_ok;
    logic [19:0] go_cnt;

    assign wr_ok = I_WRITE && !O_WAITREQUEST && I_BYTEENABLE[0];
    assign rd_ok = I_READ && !O_WAITREQUEST;

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            go_cnt <= 20'h0;
        else if (wr_ok && I_ADDRESS == 3'h3 && (I_WRITEDATA[2] || I_WRITEDATA[5]))
            go_cnt <= 20'h0;
        else if (go_cnt != 20'hfffff)
            go_cnt <= go_cnt + 20'h1;
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    a_ack_next: assert property ((I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST)
        else $error("request not answered next cycle");
    a_ack_once: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    a_no_spurious: assert property (O_WAITREQUEST && !I_READ && !I_WRITE |=> O_WAITREQUEST)
        else $error("answer without request");
    a_upper_zero: assert property (rd_ok |-> O_READDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (rd_ok && I_ADDRESS > 3'h4 |-> O_READDATA == 32'h0)
        else $error("unmapped read not zero");
    a_addr_high_bit: assert property (rd_ok && I_ADDRESS == 3'h1 |-> O_READDATA[7:1] == 7'h0)
        else $error("high address register wider than one bit");
    a_data_stable: assert property (O_WAITREQUEST |-> $stable(O_READDATA))
        else $error("read data moved between answers");
    a_done_min: assert property ($rose(O_DONE_IRQ) |-> go_cnt >= P_WRITE_S_CYC - 1)
        else $error("done raised before a timed cycle could end");
    a_done_holds: assert property (O_DONE_IRQ && !(wr_ok && I_ADDRESS == 3'h4 && I_WRITEDATA[0])
        |=> O_DONE_IRQ)
        else $error("done request dropped without a clear");

    c_done: cover property ($rose(O_DONE_IRQ));
    c_data_read: cover property (rd_ok && I_ADDRESS == 3'h2);
    c_erase_go: cover property (wr_ok && I_ADDRESS == 3'h3 && I_WRITEDATA[5]);
endmodule

bind dnpa_top dnpa_top_asserts #(
    .P_ERASE_S_CYC(P_ERASE_S_CYC),
    .P_WRITE_S_CYC(P_WRITE_S_CYC),
    .P_ERASE_L_CYC(P_ERASE_L_CYC),
    .P_WRITE_L_CYC(P_WRITE_L_CYC)
) dnpa_top_asserts_i (
    .I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N),
    .I_ADDRESS(I_ADDRESS),
    .I_READ(I_READ),
    .I_WRITE(I_WRITE),
    .I_WRITEDATA(I_WRITEDATA),
    .I_BYTEENABLE(I_BYTEENABLE),
    .O_READDATA(O_READDATA),
    .O_WAITREQUEST(O_WAITREQUEST),
    .O_DONE_IRQ(O_DONE_IRQ)
);

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam int unsigned ES = 20;
    localparam int unsigned WS = 12;
    localparam int unsigned EL = 25;
    localparam int unsigned WL = 16;
    logic        clk;
    logic        arst_n;
    logic [2:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        done_irq;
    int          errors;
    int          checks_done;
    int          cyc;
    int          start;
    logic [7:0]  exp_mem [16];

    dnpa_top #(
        .P_ERASE_S_CYC(ES),
        .P_WRITE_S_CYC(WS),
        .P_ERASE_L_CYC(EL),
        .P_WRITE_L_CYC(WL)
    ) dnpa_top_i (
        .I_CLK(clk),
        .I_ARST_N(arst_n),
        .I_ADDRESS(address),
        .I_READ(read),
        .I_WRITE(write),
        .I_WRITEDATA(writedata),
        .I_BYTEENABLE(byteenable),
        .O_READDATA(readdata),
        .O_WAITREQUEST(waitrequest),
        .O_DONE_IRQ(done_irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
        cyc <= cyc + 1;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge clk);
        address <= idx;
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        q = readdata[7:0];
        if (w && idx == 3'h3)
            start = cyc;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0)
        begin
            check(32'h0, 32'h1, "bus timeout");
            complete_run();
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [2:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        check({24'h0, q}, {24'h0, exp}, what);
    endtask

    // Cycle count from the go write to the done request, then clear it
    task automatic wait_done(input int unsigned p, input string what);
        int st;
        st = start;
        while (done_irq !== 1'b1 && cyc - st < p + 20)
            @(posedge clk);
        check({31'h0, (cyc - st >= p && cyc - st <= p + 2)}, 32'h1, what);
        if (done_irq !== 1'b1)
            complete_run();
        wr(3'h4, 8'h01);
        @(posedge clk);
        check({31'h0, done_irq}, 32'h0, "done clear");
    endtask

    task automatic set_addr(input logic [7:0] lo);
        wr(3'h0, lo);
        wr(3'h1, 8'h01);
    endtask

    task automatic rd_page();
        set_addr(8'hf0);
        wr(3'h3, 8'h12);
        for (int i = 0; i < 17; i++)
        begin
            wr(3'h3, 8'h13);
            rd_chk(3'h2, exp_mem[(i < 16) ? i : 15], "page byte");
        end
        rd_chk(3'h0, 8'hff, "read offset held");
    endtask

    // Arm, drop the arm, re-arm and go: the buffer must be empty by then
    task automatic kill_run(input logic [7:0] arm, input logic [7:0] go, input int unsigned p);
        set_addr(8'hf8);
        wr(3'h2, 8'h99);
        wr(3'h2, 8'h99);
        wr(3'h3, arm);
        wr(3'h3, 8'h90);
        wr(3'h3, arm);
        wr(3'h3, go);
        wait_done(p, "cycle length");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        arst_n = 1'b0;
        address = 3'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        start = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(3'(i), 8'h00, "reset value");
        wr(3'h5, 8'h3c);
        rd_chk(3'h5, 8'h00, "unmapped");
        byteenable <= 4'he;
        wr(3'h2, 8'h11);
        byteenable <= 4'hf;
        rd_chk(3'h2, 8'h00, "byte enable");
        $display("test registers done");
        set_addr(8'h23);
        wr(3'h2, 8'ha5);
        wr(3'h3, 8'h08);
        wr(3'h3, 8'h0c);
        rd_chk(3'h4, 8'h02, "busy");
        wr(3'h0, 8'h55);
        rd_chk(3'h3, 8'h0c, "go held");
        wait_done(WS, "write length");
        rd_chk(3'h3, 8'h00, "write bits cleared");
        wr(3'h3, 8'h02);
        wr(3'h3, 8'h03);
        rd_chk(3'h3, 8'h02, "fetch go cleared");
        rd_chk(3'h2, 8'ha5, "byte written");
        rd_chk(3'h0, 8'h23, "byte mode address");
        wr(3'h2, 8'h5a);
        wr(3'h3, 8'h00);
        wr(3'h3, 8'h01);
        rd_chk(3'h3, 8'h00, "fetch refused");
        rd_chk(3'h2, 8'h5a, "no fetch");
        wr(3'h3, 8'h04);
        rd_chk(3'h3, 8'h00, "write refused");
        repeat (WL + 4) @(posedge clk);
        check({31'h0, done_irq}, 32'h0, "no write done");
        wr(3'h3, 8'h02);
        wr(3'h3, 8'h03);
        rd_chk(3'h2, 8'ha5, "byte kept");
        $display("test byte mode done");
        wr(3'h3, 8'h10);
        set_addr(8'hf0);
        for (int i = 0; i < 16; i++)
            wr(3'h2, 8'hff);
        rd_chk(3'h0, 8'hff, "erase offset held");
        rd_chk(3'h1, 8'h01, "page kept");
        wr(3'h3, 8'h50);
        wr(3'h3, 8'h70);
        wait_done(ES, "erase length");
        rd_chk(3'h3, 8'h10, "erase bits cleared");
        set_addr(8'hf0);
        for (int i = 0; i < 17; i++)
        begin
            wr(3'h2, 8'h40 + 8'(i));
            if (i < 16)
                exp_mem[i] = 8'h40 + 8'(i);
        end
        wr(3'h3, 8'h18);
        wr(3'h3, 8'h1c);
        wait_done(WS, "page write length");
        rd_page();
        wr(3'h3, 8'h90);
        set_addr(8'hf0);
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h2, 8'h00);
            exp_mem[i] = 8'h00;
        end
        wr(3'h3, 8'hd0);
        wr(3'h3, 8'hf0);
        wait_done(EL, "long erase");
        rd_page();
        $display("test page mode done");
        wr(3'h3, 8'hd0);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'hf0);
        rd_chk(3'h3, 8'hd0, "split sequence");
        wr(3'h3, 8'h90);
        kill_run(8'hd0, 8'hf0, EL);
        kill_run(8'h98, 8'h9c, WL);
        rd_page();
        $display("test buffer clear done");
        complete_run();
    end
endmodule
